/* igu_ctrl.sv */
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module igu_ctrl
  import igu_pkg::*;
#(
  parameter int unsigned TO_CYC = igu_pkg::TIMEOUT_CYC
) (
  // clock and control
  input  wire logic             CLK,
  input  wire logic             SRST,
  input  wire logic             CE,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // input signal sign from the analogue path, bit 0 left
  input  wire logic [1:0]       SIGN_IN,
  // analogue controls
  output igu_pkg::igu_chan_s    CHAN_L,
  output igu_pkg::igu_chan_s    CHAN_R,
  output igu_pkg::igu_mix_s     MIX,
  output logic                  MIC_BIAS_OUTPUT_OE
);
  import igu_pkg::*;

  localparam int TW = $clog2(TO_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [8:0]  pwr1_r, pwr2_r, fbk_r, inctl_r, bstl_r, bstr_r;
  logic [7:0]  volc_r [2];
  logic [5:0]  act_r [2];
  igu_upd_e    st_r [2];
  logic [1:0]  tick_cnt_r [2];
  logic [TW-1:0] tmr_r;
  logic [1:0]  sgn_m_r, sgn_s_r, sgn_d_r;
  logic        pready_r, pslverr_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic [5:0] idx     = PADDR[7:2];
  wire logic       acc     = PSEL & PENABLE & pready_r;
  wire logic       wr      = acc & PWRITE & CE;
  wire logic       hit     = (PADDR[1:0] == 2'b00) &&
                             (idx == IDX_PWR1 || idx == IDX_PWR2 || idx == IDX_FBK ||
                              idx == IDX_INCTL || idx == IDX_VOLL || idx == IDX_VOLR ||
                              idx == IDX_BSTL || idx == IDX_BSTR || idx == IDX_STAT);
  wire logic       wr_ok   = wr & hit;
  wire logic       wr_voll = wr_ok & (idx == IDX_VOLL);
  wire logic       wr_volr = wr_ok & (idx == IDX_VOLR);
  wire logic       strobe  = (wr_voll | wr_volr) & PWDATA[VOL_STB_BIT];

  // pending words as they stand after this cycle's write, so a strobe obeys the zero-cross bit it carries
  logic [7:0]      pend [2];
  assign pend[0] = wr_voll ? PWDATA[7:0] : volc_r[0];
  assign pend[1] = wr_volr ? PWDATA[7:0] : volc_r[1];
  wire logic [1:0] zc_on   = {pend[1][VOL_ZC_BIT], pend[0][VOL_ZC_BIT]};

  function automatic logic [8:0] wr_field(input logic [5:0] want, input logic [8:0] cur);
    wr_field = (wr_ok && idx == want) ? PWDATA[8:0] : cur;
  endfunction

  function automatic logic [31:0] vol_rd(input logic [7:0] v);
    vol_rd = {23'h0, 1'b0, v}; // strobe bit reads as zero
  endfunction

  wire logic [31:0] rd_mux =
      (idx == IDX_PWR1)  ? {23'h0, pwr1_r}  :
      (idx == IDX_PWR2)  ? {23'h0, pwr2_r}  :
      (idx == IDX_FBK)   ? {23'h0, fbk_r}   :
      (idx == IDX_INCTL) ? {23'h0, inctl_r} :
      (idx == IDX_VOLL)  ? vol_rd(volc_r[0]) :
      (idx == IDX_VOLR)  ? vol_rd(volc_r[1]) :
      (idx == IDX_BSTL)  ? {23'h0, bstl_r}  :
      (idx == IDX_BSTR)  ? {23'h0, bstr_r}  :
      (idx == IDX_STAT)  ? {18'h0, st_r[1] == UPD_WAIT, st_r[0] == UPD_WAIT, act_r[1], act_r[0]} :
      32'h0;

  // ----------------------------------------------------------------
  // timeout timer and zero-cross detection
  // ----------------------------------------------------------------
  // free-running period; a waiting channel is forced on the second tick, so the
  // delay lands between one and two periods depending on timer phase
  wire logic tick = (tmr_r == TW'(TO_CYC - 1));
  wire logic [1:0] zc_evt = sgn_s_r ^ sgn_d_r;
  logic [1:0] apply, force_upd;

  // per-channel apply decision
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      force_upd[c] = tick && tick_cnt_r[c] == 2'd1;
      case (st_r[c])
        UPD_IDLE: apply[c] = strobe && !zc_on[c];
        UPD_WAIT: apply[c] = strobe ? !zc_on[c] : (zc_evt[c] || force_upd[c]);
        default:  apply[c] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb handshake: one wait state, answer registered
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else if (CE) begin
      pready_r  <= PSEL & PENABLE & ~pready_r;
      pslverr_r <= PSEL & PENABLE & ~pready_r & ~hit;
      if (PSEL & PENABLE & ~pready_r & ~PWRITE)
        prdata_r <= hit ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------
  // the analogue fields are used as stored; mapping codes to dB is analogue work
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pwr1_r  <= RST_PWR1;
      pwr2_r  <= RST_PWR2;
      fbk_r   <= RST_FBK;
      inctl_r <= RST_INCTL;
      bstl_r  <= RST_BST;
      bstr_r  <= RST_BST;
    end else if (CE) begin
      pwr1_r  <= wr_field(IDX_PWR1, pwr1_r);
      pwr2_r  <= wr_field(IDX_PWR2, pwr2_r);
      fbk_r   <= wr_field(IDX_FBK, fbk_r);
      inctl_r <= wr_field(IDX_INCTL, inctl_r);
      bstl_r  <= wr_field(IDX_BSTL, bstl_r);
      bstr_r  <= wr_field(IDX_BSTR, bstr_r);
    end
  end

  // ----------------------------------------------------------------
  // sign synchroniser and timer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sgn_m_r <= 2'b00;
      sgn_s_r <= 2'b00;
      sgn_d_r <= 2'b00;
      tmr_r   <= '0;
    end else if (CE) begin
      sgn_m_r <= SIGN_IN;
      sgn_s_r <= sgn_m_r;
      sgn_d_r <= sgn_s_r;
      tmr_r   <= tick ? '0 : tmr_r + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // volume: pending copy, active copy, wait state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int c = 0; c < 2; c++) begin
        volc_r[c]     <= RST_VOL[7:0];
        act_r[c]      <= RST_VOL[5:0];
        st_r[c]       <= UPD_IDLE;
        tick_cnt_r[c] <= 2'd0;
      end
    end else if (CE) begin
      if (wr_voll)
        volc_r[0] <= PWDATA[7:0];
      if (wr_volr)
        volc_r[1] <= PWDATA[7:0];
      for (int c = 0; c < 2; c++) begin
        if (apply[c]) begin
          // a strobe applies the word written with it; a deferred apply takes the stored one
          act_r[c] <= strobe ? pend[c][5:0] : volc_r[c][5:0];
          st_r[c]  <= UPD_IDLE;
        end else if (strobe && zc_on[c]) begin
          st_r[c]       <= UPD_WAIT;
          tick_cnt_r[c] <= 2'd0;
        end else if (st_r[c] == UPD_WAIT && tick) begin
          tick_cnt_r[c] <= tick_cnt_r[c] + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from registers
  // ----------------------------------------------------------------
  assign PRDATA  = prdata_r;
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  // isolate is passed alongside plus20; the analogue switch gives isolate priority
  assign CHAN_L  = '{act_r[0], volc_r[0][VOL_ISO_BIT], bstl_r[BST_PLUS20_BIT],
                     bstl_r[BST_AUX_LSB +: 3], bstl_r[BST_PIN2_LSB +: 3]};
  assign CHAN_R  = '{act_r[1], volc_r[1][VOL_ISO_BIT], bstr_r[BST_PLUS20_BIT],
                     bstr_r[BST_AUX_LSB +: 3], bstr_r[BST_PIN2_LSB +: 3]};
  assign MIX     = '{fbk_r[FBK_GAIN_LSB +: 3], fbk_r[FBK_SIDE_BIT],
                     {pwr2_r[PWR2_STGR_BIT], pwr2_r[PWR2_STGL_BIT]},
                     pwr1_r[PWR1_BIAS_BIT], inctl_r[INCTL_LVL_BIT]};
  assign MIC_BIAS_OUTPUT_OE = pwr1_r[PWR1_BIAS_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_direct_commit(int c);
    CE && strobe && st_r[c] == UPD_IDLE && !zc_on[c];
  endsequence

  property p_commit_now;
    s_direct_commit(0) |=> (act_r[0] == $past(pend[0][5:0]));
  endproperty
  a_commit_now: assert property (p_commit_now) else $error("immediate commit missed");

  property p_hold_pending;
    (CE && !apply[0]) |=> $stable(act_r[0]);
  endproperty
  a_hold_pending: assert property (p_hold_pending) else $error("volume moved without commit");

  property p_zc_waits;
    (CE && strobe && zc_on[1]) |=> (st_r[1] == UPD_WAIT);
  endproperty
  a_zc_waits: assert property (p_zc_waits) else $error("zero-cross mode did not defer");

  property p_timeout_force;
    (CE && st_r[0] == UPD_WAIT && !strobe && tick && tick_cnt_r[0] == 2'd1)
      |=> (st_r[0] == UPD_IDLE && act_r[0] == $past(volc_r[0][5:0]));
  endproperty
  a_timeout_force: assert property (p_timeout_force) else $error("timeout did not force update");

  property p_restart;
    (CE && strobe && zc_on[0]) |=> (tick_cnt_r[0] == 2'd0 && st_r[0] == UPD_WAIT);
  endproperty
  a_restart: assert property (p_restart) else $error("restrobe did not restart wait");

  property p_boost_reset;
    @(posedge CLK) $fell(SRST) |-> (CHAN_L.plus20 && CHAN_R.plus20);
  endproperty
  a_boost_reset: assert property (p_boost_reset) else $error("boost select not set after reset");

  property p_bias_hiz;
    (wr_ok && idx == IDX_PWR1) |=> (MIC_BIAS_OUTPUT_OE == $past(PWDATA[PWR1_BIAS_BIT]));
  endproperty
  a_bias_hiz: assert property (p_bias_hiz) else $error("bias enable not followed");

  property p_strobe_unstored;
    (PSEL && PENABLE && PREADY && !PWRITE && (idx == IDX_VOLL || idx == IDX_VOLR))
      |-> PRDATA[VOL_STB_BIT] == 1'b0;
  endproperty
  a_strobe_unstored: assert property (p_strobe_unstored) else $error("strobe bit read back");

  property p_ready_pulse;
    (PREADY && CE) |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over two cycles");

  // a low enable must hold the timer and the active volume where they are
  property p_freeze;
    !CE |=> ($stable(act_r[0]) && $stable(tmr_r) && $stable(pready_r));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_isolate_now;
    wr_voll |=> (CHAN_L.isolate == $past(PWDATA[VOL_ISO_BIT]));
  endproperty
  a_isolate_now: assert property (p_isolate_now) else $error("isolate not applied at once");

  property p_zc_apply;
    (CE && st_r[0] == UPD_WAIT && !strobe && zc_evt[0])
      |=> (st_r[0] == UPD_IDLE && act_r[0] == $past(volc_r[0][5:0]));
  endproperty
  a_zc_apply: assert property (p_zc_apply) else $error("zero crossing did not apply volume");

  property p_routing_now;
    (wr_ok && idx == IDX_BSTR) |=> (CHAN_R.plus20 == $past(PWDATA[BST_PLUS20_BIT]) &&
                                    CHAN_R.pin2_gain == $past(PWDATA[BST_PIN2_LSB +: 3]));
  endproperty
  a_routing_now: assert property (p_routing_now) else $error("boost routing not followed");

  property p_stage_power;
    (wr_ok && idx == IDX_PWR2) |=> (MIX.stage_on == $past({PWDATA[PWR2_STGR_BIT], PWDATA[PWR2_STGL_BIT]}));
  endproperty
  a_stage_power: assert property (p_stage_power) else $error("stage power not followed");

endmodule

/* igu_pkg.sv */
package igu_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 20;
  localparam int unsigned TIMEOUT_NS  = 10_000_000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PWR1  = 6'h01;
  localparam logic [5:0] IDX_PWR2  = 6'h02;
  localparam logic [5:0] IDX_FBK   = 6'h2a;
  localparam logic [5:0] IDX_INCTL = 6'h2c;
  localparam logic [5:0] IDX_VOLL  = 6'h2d;
  localparam logic [5:0] IDX_VOLR  = 6'h2e;
  localparam logic [5:0] IDX_BSTL  = 6'h2f;
  localparam logic [5:0] IDX_BSTR  = 6'h30;
  localparam logic [5:0] IDX_STAT  = 6'h3f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned VOL_ISO_BIT    = 6;
  localparam int unsigned VOL_ZC_BIT     = 7;
  localparam int unsigned VOL_STB_BIT    = 8;
  localparam int unsigned BST_PLUS20_BIT = 8;
  localparam int unsigned BST_AUX_LSB    = 0;
  localparam int unsigned BST_PIN2_LSB   = 4;
  localparam int unsigned FBK_GAIN_LSB   = 6;
  localparam int unsigned FBK_SIDE_BIT   = 5;
  localparam int unsigned PWR2_STGL_BIT  = 4;
  localparam int unsigned PWR2_STGR_BIT  = 5;
  localparam int unsigned PWR1_BIAS_BIT  = 4;
  localparam int unsigned INCTL_LVL_BIT  = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] RST_PWR1  = 9'h000;
  localparam logic [8:0] RST_PWR2  = 9'h000;
  localparam logic [8:0] RST_FBK   = 9'h000;
  localparam logic [8:0] RST_INCTL = 9'h033;
  localparam logic [8:0] RST_VOL   = 9'h010;
  localparam logic [8:0] RST_BST   = 9'h100;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    UPD_IDLE = 1'b0,
    UPD_WAIT = 1'b1
  } igu_upd_e;

  typedef struct packed {
    logic [5:0] gain;
    logic       isolate;
    logic       plus20;
    logic [2:0] aux_gain;
    logic [2:0] pin2_gain;
  } igu_chan_s;

  typedef struct packed {
    logic [2:0] fbk_gain;
    logic       fbk_side;
    logic [1:0] stage_on;
    logic       bias_on;
    logic       bias_level;
  } igu_mix_s;

endpackage

/* igu_tb.sv */
`timescale 1ns/1ps

module testbench;
  import igu_pkg::*;
  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  localparam int TO = 32;  // short timeout keeps the deferred cases brief
  logic CLK, SRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [1:0] SIGN_IN;
  igu_chan_s CHAN_L, CHAN_R;
  igu_mix_s MIX;
  logic err;
  int error_cnt, n_checks;

  igu_ctrl #(.TO_CYC(TO)) dut (.CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SIGN_IN(SIGN_IN), .CHAN_L(CHAN_L), .CHAN_R(CHAN_R), .MIX(MIX),
    .MIC_BIAS_OUTPUT_OE(OE));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits for an edge first so two transfers never drive a signal twice in one step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [5:0] idx [7] = '{IDX_PWR1, IDX_PWR2, IDX_FBK, IDX_INCTL, IDX_VOLL, IDX_BSTL, IDX_BSTR};
    logic [8:0] rv  [7] = '{9'h000, 9'h000, 9'h000, 9'h033, 9'h010, 9'h100, 9'h100};
    for (int i = 0; i < 7; i++) rdchk(idx[i], {23'h0, rv[i]});
    chk({18'h0, CHAN_L}, 32'h1040);
    chk({24'h0, MIX}, 32'h0);
    chk({31'h0, OE}, 32'h0);
  endtask

  task automatic t_fields;
    apb(1'b1, IDX_BSTL, 32'h057);
    apb(1'b1, IDX_BSTR, 32'h131);
    apb(1'b1, IDX_FBK, 32'h1a0);
    apb(1'b1, IDX_PWR2, 32'h010);
    apb(1'b1, IDX_PWR1, 32'h010);
    apb(1'b1, IDX_INCTL, 32'h133);
    apb(1'b1, IDX_VOLL, 32'h050);
    settle(2);
    chk({18'h0, CHAN_L}, 32'h10bd);
    chk({18'h0, CHAN_R}, 32'h104b);
    chk({24'h0, MIX}, 32'hd7);
    chk({31'h0, OE}, 32'h1);
    rdchk(IDX_FBK, 32'h1a0);
    rdchk(IDX_BSTL, 32'h057);
  endtask

  // unmapped index must be refused and must read as zero
  task automatic t_unmapped;
    apb(1'b1, 6'h03, 32'h1ff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 6'h03, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_commit;
    apb(1'b1, IDX_VOLL, 32'h020);
    settle(3);
    chk({26'h0, CHAN_L.gain}, 32'h10);
    apb(1'b1, IDX_VOLR, 32'h13f);
    settle(1);
    chk({26'h0, CHAN_L.gain}, 32'h20);
    chk({26'h0, CHAN_R.gain}, 32'h3f);
    chk({31'h0, CHAN_L.isolate}, 32'h0);
    rdchk(IDX_VOLR, 32'h03f);
  endtask

  task automatic t_zero_cross;
    apb(1'b1, IDX_VOLR, 32'h0ab);
    apb(1'b1, IDX_VOLL, 32'h18a);
    settle(3);
    chk({26'h0, CHAN_L.gain}, 32'h20);
    @(posedge CLK);
    SIGN_IN[0] <= ~SIGN_IN[0];
    settle(5);
    chk({26'h0, CHAN_L.gain}, 32'h0a);
    chk({26'h0, CHAN_R.gain}, 32'h3f);
    @(posedge CLK);
    SIGN_IN[1] <= ~SIGN_IN[1];
    settle(5);
    chk({26'h0, CHAN_R.gain}, 32'h2b);
  endtask

  // a second strobe mid-wait must take the newer value and restart the wait
  task automatic t_timeout;
    int n;
    apb(1'b1, IDX_VOLL, 32'h085);
    apb(1'b1, IDX_VOLR, 32'h186);
    settle(5);
    apb(1'b1, IDX_VOLL, 32'h187);
    n = 0;
    do begin
      settle(1);
      n++;
    end while (CHAN_L.gain === 6'h0a && n < 4 * TO);
    chk({26'h0, CHAN_L.gain}, 32'h07);
    chk({26'h0, CHAN_R.gain}, 32'h06);
    chk({31'h0, n >= TO && n <= 2 * TO}, 32'h1);
  endtask

  // a low enable freezes the timeout, so the forced update waits out the frozen span
  task automatic t_freeze;
    int n;
    apb(1'b1, IDX_VOLL, 32'h1a0);
    @(posedge CLK);
    CE <= 1'b0;
    settle(3 * TO);
    chk({26'h0, CHAN_L.gain}, 32'h07);
    @(posedge CLK);
    CE <= 1'b1;
    n = 0;
    do begin
      settle(1);
      n++;
    end while (CHAN_L.gain === 6'h07 && n < 4 * TO);
    chk({26'h0, CHAN_L.gain}, 32'h20);
    chk({31'h0, n <= 2 * TO}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // generous limit: the whole sequence needs well under a thousand cycles
  initial begin
    #(20 * 20000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    SRST = 1'b1;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    SIGN_IN = 2'b00;
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    t_reset();
    t_fields();
    t_unmapped();
    t_commit();
    t_zero_cross();
    t_timeout();
    t_freeze();
    tally_and_finish();
  end
endmodule
